// File: dpg_regs.svh
// register map, field positions, reset values for the dual gpio port block
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef DPG_REGS_SVH
`define DPG_REGS_SVH

// ----------------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define DPG_IDX_PORT_C_PIN_LATCH 4'h2
`define DPG_IDX_PORT_D_PIN_LATCH 4'h3
`define DPG_IDX_PORT_C_DIRECTION 4'h6
`define DPG_IDX_PORT_D_DIRECTION 4'h7
`define DPG_IDX_ALT_FUNC_CTRL    4'h8
`define DPG_ADDR_W               6
`define DPG_BYTE_ADDR(idx)       ({(idx), 2'h0})

// ----------------------------------------------------------------------
// alternate function control fields
// ----------------------------------------------------------------------
`define DPG_BIT_LOWER_DISPLAY    0
`define DPG_BIT_UPPER_DISPLAY    1
`define DPG_BIT_SERIAL_ENABLE    2
`define DPG_KEYPAD_LSB           4
`define DPG_KEYPAD_MSB           7

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define DPG_DIRECTION_RESET      8'h00
`define DPG_ALT_CTRL_RESET       8'h00
`define DPG_RESP_OKAY            2'h0
`define DPG_RESP_SLVERR          2'h2

`endif

// File: dpg_pkg.sv
// types for the dual gpio port block
// assumes dpg_regs.svh is on the include path
`default_nettype none
`include "dpg_regs.svh"

package dpg_pkg;

  // --------------------------------------------------------------------
  // complete register state of the block
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                pc_latch;
    logic [7:0]                pd_latch;
    logic [7:0]                pc_dir;
    logic [7:0]                pd_dir;
    logic [7:0]                alt_ctl;
    logic [7:0]                pc_out;
    logic [7:0]                pc_oe;
    logic [7:0]                pd_out;
    logic [7:0]                pd_oe;
    logic [3:0]                kbd;
    logic [3:0]                spi_in;
    logic                      awready;
    logic                      wready;
    logic                      aw_have;
    logic [`DPG_ADDR_W-1:0]    aw_addr;
    logic                      w_have;
    logic [7:0]                w_data;
    logic                      w_lane0;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
  } dpg_state_t;

endpackage : dpg_pkg
`default_nettype wire

// File: dpg_gpio.sv
// two 8-bit gpio ports with display, serial and keypad pin takeover
// assumes an axi4-lite master on aclk; pins and alternate sources
// are synchronous to aclk
// data latches power up unknown until software writes them
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "dpg_regs.svh"

// Functional notes
// - port c data latch, read/write
// - reset keeps port c latches
// - port c direction, one drives pin
// - reset clears port c direction
// - port c read: latch if output, else pin
// - latch writes land whenever lane 0 is set, inputs unaffected
// - port c halves go to display frontplanes
// - port d data latch, kept over reset
// - reset keeps port d latches
// - port d direction, one drives pin
// - reset clears port d direction
// - port d read: latch if output, else pin
// - serial enable takes port d pins 0-3
// - keypad enables take port d pins 4-7
// - direction registers read back last write
module dpg_gpio
  import dpg_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`DPG_ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                   s_axil_awvalid,
  output var  logic                   s_axil_awready,
  input  wire logic [31:0]            s_axil_wdata,
  input  wire logic [3:0]             s_axil_wstrb,
  input  wire logic                   s_axil_wvalid,
  output var  logic                   s_axil_wready,
  output var  logic [1:0]             s_axil_bresp,
  output var  logic                   s_axil_bvalid,
  input  wire logic                   s_axil_bready,
  input  wire logic [`DPG_ADDR_W-1:0] s_axil_araddr,
  input  wire logic                   s_axil_arvalid,
  output var  logic                   s_axil_arready,
  output var  logic [31:0]            s_axil_rdata,
  output var  logic [1:0]             s_axil_rresp,
  output var  logic                   s_axil_rvalid,
  input  wire logic                   s_axil_rready,
  input  wire logic [7:0]             port_c_pin_in,
  output var  logic [7:0]             port_c_pin_out,
  output var  logic [7:0]             port_c_pin_oe,
  input  wire logic [7:0]             port_d_pin_in,
  output var  logic [7:0]             port_d_pin_out,
  output var  logic [7:0]             port_d_pin_oe,
  input  wire logic [7:0]             display_frontplane_outputs,
  input  wire logic [3:0]             serial_pin_out,
  input  wire logic [3:0]             serial_pin_oe,
  output var  logic [3:0]             serial_pin_in,
  output var  logic [3:0]             keypad_wake_inputs,
  output var  logic                   upper_half_display_enable,
  output var  logic                   lower_half_display_enable,
  output var  logic                   serial_interface_enable,
  output var  logic [3:0]             keypad_input_enables
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dpg_state_t st_reg;
  dpg_state_t st_next;

  // ----------------------------------------------------------------------
  // pin steering, one slice per pin
  // ----------------------------------------------------------------------
  wire logic [7:0] pc_out_sel;
  wire logic [7:0] pc_oe_sel;
  wire logic [7:0] pd_out_sel;
  wire logic [7:0] pd_oe_sel;

  // takeover only steers the pins; latch and direction keep what was written
  for (genvar g = 0; g < 8; g++)
  begin : g_pin
    localparam int DISP_BIT = (g < 4) ? `DPG_BIT_LOWER_DISPLAY : `DPG_BIT_UPPER_DISPLAY;
    wire logic pc_alt;
    wire logic pd_alt;
    wire logic pd_alt_out;
    wire logic pd_alt_oe;
    assign pc_alt = st_reg.alt_ctl[DISP_BIT];
    if (g < 4)
    begin : g_serial
      // the serial block picks its own direction per pin, so it is passed on
      assign pd_alt     = st_reg.alt_ctl[`DPG_BIT_SERIAL_ENABLE];
      assign pd_alt_out = serial_pin_out[g];
      assign pd_alt_oe  = serial_pin_oe[g];
    end
    else
    begin : g_keypad
      // a keypad pin is input only, so its buffer stays off
      assign pd_alt     = st_reg.alt_ctl[g];
      assign pd_alt_out = 1'b0;
      assign pd_alt_oe  = 1'b0;
    end
    // a display half drives its pins whatever the direction bits say
    assign pc_out_sel[g] = pc_alt ? display_frontplane_outputs[g] : st_reg.pc_latch[g];
    assign pc_oe_sel[g]  = pc_alt ? 1'b1 : st_reg.pc_dir[g];
    assign pd_out_sel[g] = pd_alt ? pd_alt_out : st_reg.pd_latch[g];
    assign pd_oe_sel[g]  = pd_alt ? pd_alt_oe : st_reg.pd_dir[g];
  end

  // ----------------------------------------------------------------------
  // read mux; decode error answers zero data
  // ----------------------------------------------------------------------
  function automatic logic [32:0] dpg_read
  (
    input dpg_state_t             s,
    input logic [`DPG_ADDR_W-1:0] addr,
    input logic [7:0]             pc_pins,
    input logic [7:0]             pd_pins
  );
    logic [32:0] res;
    res = {1'b1, 32'h0000_0000};
    if (addr == `DPG_BYTE_ADDR(`DPG_IDX_PORT_C_PIN_LATCH))
    begin
      res = {1'b0, 24'h00_0000, (s.pc_dir & s.pc_latch) | (~s.pc_dir & pc_pins)};
    end
    else if (addr == `DPG_BYTE_ADDR(`DPG_IDX_PORT_D_PIN_LATCH))
    begin
      res = {1'b0, 24'h00_0000, (s.pd_dir & s.pd_latch) | (~s.pd_dir & pd_pins)};
    end
    else if (addr == `DPG_BYTE_ADDR(`DPG_IDX_PORT_C_DIRECTION))
    begin
      res = {1'b0, 24'h00_0000, s.pc_dir};
    end
    else if (addr == `DPG_BYTE_ADDR(`DPG_IDX_PORT_D_DIRECTION))
    begin
      res = {1'b0, 24'h00_0000, s.pd_dir};
    end
    else if (addr == `DPG_BYTE_ADDR(`DPG_IDX_ALT_FUNC_CTRL))
    begin
      res = {1'b0, 24'h00_0000, s.alt_ctl};
    end
    return res;
  endfunction : dpg_read

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [32:0] rd;
    logic        hit;
    rd      = 33'h0_0000_0000;
    hit     = 1'b0;
    st_next = st_reg;

    // pin drive comes from the steering slices
    st_next.pc_out = pc_out_sel;
    st_next.pc_oe  = pc_oe_sel;
    st_next.pd_out = pd_out_sel;
    st_next.pd_oe  = pd_oe_sel;

    // pin levels handed to the serial and keypad logic
    st_next.spi_in = st_reg.alt_ctl[`DPG_BIT_SERIAL_ENABLE] ? port_d_pin_in[3:0] : 4'h0;
    st_next.kbd    = st_reg.alt_ctl[`DPG_KEYPAD_MSB:`DPG_KEYPAD_LSB] & port_d_pin_in[7:4];

    // write address and data are taken in either order
    // readys drop while a half is held, so a second write waits for the answer
    if (st_reg.awready && s_axil_awvalid)
    begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axil_awaddr;
    end
    if (st_reg.wready && s_axil_wvalid)
    begin
      st_next.w_have  = 1'b1;
      st_next.w_data  = s_axil_wdata[7:0];
      st_next.w_lane0 = s_axil_wstrb[0];
    end
    if (st_reg.bvalid && s_axil_bready)
    begin
      st_next.bvalid = 1'b0;
    end

    // commit once both halves are held; latches take any write with lane 0 set
    // a write with lane 0 off is answered but changes nothing
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid)
    begin
      hit = 1'b1;
      unique case (st_reg.aw_addr)
        `DPG_BYTE_ADDR(`DPG_IDX_PORT_C_PIN_LATCH):
        begin
          if (st_reg.w_lane0) st_next.pc_latch = st_reg.w_data;
        end
        `DPG_BYTE_ADDR(`DPG_IDX_PORT_D_PIN_LATCH):
        begin
          if (st_reg.w_lane0) st_next.pd_latch = st_reg.w_data;
        end
        `DPG_BYTE_ADDR(`DPG_IDX_PORT_C_DIRECTION):
        begin
          if (st_reg.w_lane0) st_next.pc_dir = st_reg.w_data;
        end
        `DPG_BYTE_ADDR(`DPG_IDX_PORT_D_DIRECTION):
        begin
          if (st_reg.w_lane0) st_next.pd_dir = st_reg.w_data;
        end
        `DPG_BYTE_ADDR(`DPG_IDX_ALT_FUNC_CTRL):
        begin
          if (st_reg.w_lane0) st_next.alt_ctl = st_reg.w_data;
        end
        default:
        begin
          hit = 1'b0;
        end
      endcase
      st_next.bresp   = hit ? `DPG_RESP_OKAY : `DPG_RESP_SLVERR;
      st_next.bvalid  = 1'b1;
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready  = !st_next.w_have && !st_next.bvalid;

    // read channel answers on the same edge that takes the address
    // pins are read at the accept edge; a pin that moves later is not seen
    if (st_reg.rvalid && s_axil_rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.arready && s_axil_arvalid)
    begin
      rd             = dpg_read(st_reg, s_axil_araddr, port_c_pin_in, port_d_pin_in);
      st_next.rdata  = rd[31:0];
      st_next.rresp  = rd[32] ? `DPG_RESP_SLVERR : `DPG_RESP_OKAY;
      st_next.rvalid = 1'b1;
    end
    st_next.arready = !st_next.rvalid;

    // synchronous reset; data latches deliberately untouched
    // readys stay low for the reset edge and rise on the first edge after it
    if (!aresetn)
    begin
      st_next.pc_dir  = `DPG_DIRECTION_RESET;
      st_next.pd_dir  = `DPG_DIRECTION_RESET;
      st_next.alt_ctl = `DPG_ALT_CTRL_RESET;
      st_next.pc_out  = 8'h00;
      st_next.pc_oe   = 8'h00;
      st_next.pd_out  = 8'h00;
      st_next.pd_oe   = 8'h00;
      st_next.kbd     = 4'h0;
      st_next.spi_in  = 4'h0;
      st_next.awready = 1'b0;
      st_next.wready  = 1'b0;
      st_next.aw_have = 1'b0;
      st_next.aw_addr = '0;
      st_next.w_have  = 1'b0;
      st_next.w_data  = 8'h00;
      st_next.w_lane0 = 1'b0;
      st_next.bvalid  = 1'b0;
      st_next.bresp   = `DPG_RESP_OKAY;
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b0;
      st_next.rresp   = `DPG_RESP_OKAY;
      st_next.rdata   = 32'h0000_0000;
      st_next.pc_latch = st_reg.pc_latch;
      st_next.pd_latch = st_reg.pd_latch;
    end
  end

  // ----------------------------------------------------------------------
  // register
  // ----------------------------------------------------------------------
  // no reset branch here: reset is folded into the next-state logic
  // so that the data latches ride through it untouched
  always_ff @(posedge aclk)
  begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  // pins follow one edge after the state that steers them
  assign s_axil_awready = st_reg.awready;
  assign s_axil_wready  = st_reg.wready;
  assign s_axil_bresp   = st_reg.bresp;
  assign s_axil_bvalid  = st_reg.bvalid;
  assign s_axil_arready = st_reg.arready;
  assign s_axil_rdata   = st_reg.rdata;
  assign s_axil_rresp   = st_reg.rresp;
  assign s_axil_rvalid  = st_reg.rvalid;
  assign port_c_pin_out = st_reg.pc_out;
  assign port_c_pin_oe  = st_reg.pc_oe;
  assign port_d_pin_out = st_reg.pd_out;
  assign port_d_pin_oe  = st_reg.pd_oe;
  assign serial_pin_in  = st_reg.spi_in;
  assign keypad_wake_inputs        = st_reg.kbd;
  assign upper_half_display_enable = st_reg.alt_ctl[`DPG_BIT_UPPER_DISPLAY];
  assign lower_half_display_enable = st_reg.alt_ctl[`DPG_BIT_LOWER_DISPLAY];
  assign serial_interface_enable   = st_reg.alt_ctl[`DPG_BIT_SERIAL_ENABLE];
  assign keypad_input_enables      = st_reg.alt_ctl[`DPG_KEYPAD_MSB:`DPG_KEYPAD_LSB];

endmodule : dpg_gpio
`default_nettype wire

// File: dpg_gpio_properties.sv
// concurrent checks on bus and pin ports of the dual gpio block
// assumes aclk with the synchronous active-low aresetn of that block
`timescale 1ns/10ps
`default_nettype none
module dpg_gpio_props (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axil_awvalid,
  input  wire logic        s_axil_awready,
  input  wire logic        s_axil_wvalid,
  input  wire logic        s_axil_wready,
  input  wire logic        s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic        s_axil_arvalid,
  input  wire logic        s_axil_arready,
  input  wire logic        s_axil_rvalid,
  input  wire logic [31:0] s_axil_rdata,
  input  wire logic [7:0]  port_c_pin_out,
  input  wire logic [7:0]  port_c_pin_oe,
  input  wire logic [7:0]  port_d_pin_oe,
  input  wire logic [7:0]  display_frontplane_outputs,
  input  wire logic [3:0]  serial_pin_oe,
  input  wire logic        upper_half_display_enable,
  input  wire logic        serial_interface_enable,
  input  wire logic [3:0]  keypad_input_enables
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------
  // write steps
  // ----------
  sequence s_wr_take;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence s_wr_answer;
    !s_axil_awready && !s_axil_wready ##1 s_axil_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_wr_answer)
    else $error("write answer not on time");
  a_write_release: assert property (s_axil_bvalid && s_axil_bready |=>
    !s_axil_bvalid && s_axil_awready && s_axil_wready) else $error("write not released");
  a_read_answer: assert property (s_axil_arvalid && s_axil_arready |=>
    s_axil_rvalid && !s_axil_arready) else $error("read answer not on time");
  a_rdata_upper: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_inputs: assert property (!$past(aresetn) |->
    port_c_pin_oe == 8'h00 && port_d_pin_oe == 8'h00 && !s_axil_bvalid)
    else $error("pins driven after reset");
  // ----------
  // pin takeover
  // ----------
  a_upper_display: assert property (upper_half_display_enable [*2] |->
    port_c_pin_oe[7:4] == 4'hF && port_c_pin_out[7:4] == $past(display_frontplane_outputs[7:4]))
    else $error("upper frontplanes not on pins");
  a_serial_owns: assert property (serial_interface_enable [*2] |->
    port_d_pin_oe[3:0] == $past(serial_pin_oe)) else $error("serial drive not on pins");
  a_keypad_owns: assert property (
    (port_d_pin_oe[7:4] & keypad_input_enables & $past(keypad_input_enables)) == 4'h0)
    else $error("keypad pin still driven");
endmodule : dpg_gpio_props

bind dpg_gpio dpg_gpio_props u_props (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready,
  .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid,
  .s_axil_arready, .s_axil_rvalid, .s_axil_rdata, .port_c_pin_out, .port_c_pin_oe,
  .port_d_pin_oe, .display_frontplane_outputs, .serial_pin_oe, .upper_half_display_enable,
  .serial_interface_enable, .keypad_input_enables);
`default_nettype wire

// File: dpg_pin_board.sv
// board model behind the port c and port d pins
// assumes the bench gives the level a released pin settles to
`timescale 1ns/10ps
`default_nettype none
module dpg_pin_board (
  input  wire logic [7:0] port_c_pin_out,
  input  wire logic [7:0] port_c_pin_oe,
  input  wire logic [7:0] port_d_pin_out,
  input  wire logic [7:0] port_d_pin_oe,
  input  wire logic [7:0] board_c,
  input  wire logic [7:0] board_d,
  output var  logic [7:0] port_c_pin_in,
  output var  logic [7:0] port_d_pin_in
);
  // no pulls: the bench reshuffles board levels so a stale value never passes
  assign port_c_pin_in = (port_c_pin_out & port_c_pin_oe) | (board_c & ~port_c_pin_oe);
  assign port_d_pin_in = (port_d_pin_out & port_d_pin_oe) | (board_d & ~port_d_pin_oe);
endmodule : dpg_pin_board
`default_nettype wire

// File: test_dpg_gpio.sv
// self-checking bench for the dual gpio block with a board pin model
// assumes dpg_regs.svh on the include path and the checker bound in
`timescale 1ns/10ps
`default_nettype none
`include "dpg_regs.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_dpg_gpio;
  localparam logic [5:0] A_LC = `DPG_BYTE_ADDR(`DPG_IDX_PORT_C_PIN_LATCH);
  localparam logic [5:0] A_LD = `DPG_BYTE_ADDR(`DPG_IDX_PORT_D_PIN_LATCH);
  localparam logic [5:0] A_DC = `DPG_BYTE_ADDR(`DPG_IDX_PORT_C_DIRECTION);
  localparam logic [5:0] A_DD = `DPG_BYTE_ADDR(`DPG_IDX_PORT_D_DIRECTION);
  localparam logic [5:0] A_AL = `DPG_BYTE_ADDR(`DPG_IDX_ALT_FUNC_CTRL);
  logic        aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
  logic        s_axil_rready, upper_half_display_enable, lower_half_display_enable;
  logic        serial_interface_enable;
  logic [5:0]  s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, seed, v, w;
  logic [3:0]  s_axil_wstrb, serial_pin_out, serial_pin_oe, serial_pin_in;
  logic [3:0]  keypad_wake_inputs, keypad_input_enables;
  logic [1:0]  s_axil_bresp, s_axil_rresp;
  logic [7:0]  port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_d_pin_in, port_d_pin_out;
  logic [7:0]  port_d_pin_oe, display_frontplane_outputs, ext_c, ext_d;
  logic [7:0]  mc, md, dc, dd, alt, cm, sm, km, eoe, eout, lvl;
  int          error_cnt, checks, cyc;

  dpg_gpio uut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
    .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .port_c_pin_in,
    .port_c_pin_out, .port_c_pin_oe, .port_d_pin_in, .port_d_pin_out, .port_d_pin_oe,
    .display_frontplane_outputs, .serial_pin_out, .serial_pin_oe, .serial_pin_in,
    .keypad_wake_inputs, .upper_half_display_enable, .lower_half_display_enable,
    .serial_interface_enable, .keypad_input_enables);
  dpg_pin_board board (.port_c_pin_out, .port_c_pin_oe, .port_d_pin_out, .port_d_pin_oe,
    .board_c(ext_c), .board_d(ext_d), .port_c_pin_in, .port_d_pin_in);

  // ----------
  // clock, bus tasks, closing
  // ----------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] lv(input logic [7:0] o, input logic [7:0] e, input logic [7:0] x);
    return (o & e) | (x & ~e);
  endfunction : lv

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h0, d};
    s_axil_wstrb <= s;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axil_awready)
        s_axil_awvalid <= 1'b0;
      if (s_axil_wready)
        s_axil_wvalid <= 1'b0;
    end
    while (!s_axil_bvalid);
    `CHK("bresp", r, s_axil_bresp)
    s_axil_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axil_arready)
        s_axil_arvalid <= 1'b0;
    end
    while (!s_axil_rvalid);
    `CHK("rdata", {24'h0, e}, s_axil_rdata)
    `CHK("rresp", r, s_axil_rresp)
    s_axil_rready <= 1'b0;
  endtask : rd

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // hang guard: a full run needs well under 2000 cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  // ----------
  // main sequence
  // ----------
  initial
  begin
    seed = 32'h0000F924;
    {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata, s_axil_wstrb} = '0;
    {serial_pin_out, serial_pin_oe, display_frontplane_outputs, ext_c, ext_d} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      v = rnd();
      w = rnd();
      ext_c <= v[7:0];
      ext_d <= v[15:8];
      display_frontplane_outputs <= v[23:16];
      serial_pin_out <= v[27:24];
      serial_pin_oe <= v[31:28];
      if (i == 0 || i == 12)
      begin
        if (i == 12)
        begin
          aresetn <= 1'b0;
          repeat (2) @(posedge aclk);
          aresetn <= 1'b1;
          wr(A_DC, 8'hFF, 4'h1, 2'h0);
          wr(A_DD, 8'hFF, 4'h1, 2'h0);
          rd(A_LC, mc, 2'h0);
          rd(A_LD, md, 2'h0);
          aresetn <= 1'b0;
          repeat (2) @(posedge aclk);
          aresetn <= 1'b1;
        end
        rd(A_DC, 8'h00, 2'h0);
        rd(A_DD, 8'h00, 2'h0);
      end
      // latches go in before directions so no pin shows a stale level
      wr(A_LC, w[7:0], {3'h0, w[24] | (i == 0)}, 2'h0);
      if (w[24] | (i == 0))
        mc = w[7:0];
      wr(A_LD, w[15:8], {3'h0, w[25] | (i == 0)}, 2'h0);
      if (w[25] | (i == 0))
        md = w[15:8];
      dc = w[23:16];
      dd = (i == 0) ? 8'hFF : w[31:24];
      alt = v[7:0] ^ v[31:24];
      wr(A_DC, dc, 4'hF, 2'h0);
      wr(A_DD, dd, 4'hF, 2'h0);
      wr(A_AL, alt, 4'hF, 2'h0);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      cm = {{4{alt[1]}}, {4{alt[0]}}};
      sm = {4'h0, {4{alt[2]}}};
      km = {alt[7:4], 4'h0};
      eoe = cm | (dc & ~cm);
      eout = (display_frontplane_outputs & cm) | (mc & ~cm);
      `CHK("c oe", eoe, port_c_pin_oe)
      `CHK("c out", eout & eoe, port_c_pin_out & eoe)
      lvl = lv(eout, eoe, ext_c);
      rd(A_LC, (mc & dc) | (lvl & ~dc), 2'h0);
      eoe = ({4'h0, serial_pin_oe} & sm) | (dd & ~sm & ~km);
      eout = ({4'h0, serial_pin_out} & sm) | (md & ~sm & ~km);
      `CHK("d oe", eoe, port_d_pin_oe)
      `CHK("d out", eout & eoe, port_d_pin_out & eoe)
      lvl = lv(eout, eoe, ext_d);
      `CHK("ser in", alt[2] ? lvl[3:0] : 4'h0, serial_pin_in)
      `CHK("kbd", lvl[7:4] & alt[7:4], keypad_wake_inputs)
      `CHK("en", {alt[7:4], alt[2:0]}, {keypad_input_enables, serial_interface_enable, upper_half_display_enable, lower_half_display_enable})
      rd(A_LD, (md & dd) | (lvl & ~dd), 2'h0);
      rd(A_DC, dc, 2'h0);
      rd(A_DD, dd, 2'h0);
      rd(A_AL, alt, 2'h0);
    end
    wr(6'h04, 8'h5A, 4'hF, 2'h2);
    rd(6'h24, 8'h00, 2'h2);
    finish_test();
  end
endmodule : test_dpg_gpio
`default_nettype wire
